// *** stopwatch_params.svh ***
// Register map, field positions, reset values and count limits
`ifndef STOPWATCH_PARAMS_SVH
`define STOPWATCH_PARAMS_SVH

// ********************************************************
// Register indices on the nibble register port
// ********************************************************
`define SW_IDX_CTRL_A 3'h0
`define SW_IDX_CTRL_B 3'h1
`define SW_IDX_DIG_L 3'h2
`define SW_IDX_DIG_M 3'h3
`define SW_IDX_DIG_H 3'h4

// ********************************************************
// Field positions
// ********************************************************
`define SW_A_RUN 3
`define SW_A_PIN 2
`define SW_A_MEAS 1
`define SW_A_CLR 0
`define SW_B_DEB 3
`define SW_B_EDGE 2
`define SW_B_IRQP 1
`define SW_B_SECF 0

// ********************************************************
// Reset values and count limits
// ********************************************************
`define SW_RST_BIT 1'b0
`define SW_RST_NIBBLE 4'h0
`define SW_DIGIT_MAX 4'h9
`define SW_COUNT_ZERO 12'h000
`define SW_COUNT_PRE_TOP 12'h998
`define SW_COUNT_TOP 12'h999
`define SW_LOW_TOP 8'h99

`endif

// *** stopwatch_pkg.sv ***
// Types shared by the stopwatch design files
package stopwatch_pkg;

    // One register nibble or one BCD digit
    typedef logic [3:0] nibble_t;

    // Run state of the counter
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN_CPU,
        ST_ARMED,
        ST_RUN_PIN,
        ST_WAIT_STOP
    } run_state_t;

endpackage

// *** trigger_debounce.sv ***
// Debouncer for the synchronised trigger pin level
`timescale 1ns/10ps
`default_nettype none
`include "stopwatch_params.svh"

module trigger_debounce #(
    parameter int SAMPLES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_level,
    input wire logic tap_tick,
    output logic stable
);

    logic [SAMPLES-1:0] samples_ff;

    // ********************************************************
    // Sample on the debounce tap, accept a level only once
    // every sample agrees; reset to the pulled-up idle level
    // so no false trigger edge follows reset
    // ********************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            samples_ff <= '1;
        end else if (tap_tick) begin
            samples_ff <= {samples_ff[SAMPLES-2:0], pin_level};
        end
    end

    // Stable level moves only on full agreement, so a bounce
    // shorter than one tap period never reaches the counter
    always_ff @(posedge clk) begin
        if (rst) begin
            stable <= 1'b1; // Idle pin level
        end else if (&samples_ff) begin
            stable <= 1'b1;
        end else if (~|samples_ff) begin
            stable <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** bcd_count.sv ***
// Three digit BCD millisecond counter with carry outputs
`timescale 1ns/10ps
`default_nettype none
`include "stopwatch_params.svh"

module bcd_count #(
    parameter int DIGITS = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic advance,
    output logic [4*DIGITS-1:0] count,
    output logic tenth_carry,
    output logic wrap
);
    import stopwatch_pkg::*;

    logic [DIGITS:0] carry;

    assign carry[0] = advance;
    // Carry out of the two low digits marks a tenth of a second
    assign tenth_carry = carry[2] & ~clear;
    assign wrap = carry[DIGITS] & ~clear;

    // ********************************************************
    // One decade per digit, carry chained upward
    // ********************************************************
    genvar i;
    generate
        for (i = 0; i < DIGITS; i++) begin : g_digit
            nibble_t dig;
            assign dig = count[4*i +: 4];
            assign carry[i+1] = carry[i] & (dig == `SW_DIGIT_MAX);
            // Clear beats an advance in the same cycle
            always_ff @(posedge clk) begin
                if (rst || clear) begin
                    count[4*i +: 4] <= `SW_RST_NIBBLE;
                end else if (carry[i]) begin
                    count[4*i +: 4] <= (dig == `SW_DIGIT_MAX) ?
                        `SW_RST_NIBBLE : dig + 4'h1;
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// *** millisecond_bcd_stopwatch.sv ***
// Millisecond BCD stopwatch with register port and pin trigger
//
// Contract
// - Pin trigger is debounced on the fast or slow prescaler tap.
// - Debounce select resets to fast tap; irq period to a tenth.
// - Edge select picks active edge, 0 falling; ignored under CPU.
// - Trigger edge select is private to this counter.
// - Interrupt request every tenth second or every second.
// - Internal trigger is pin level when select is 1, else inverted.
// - Pulse mode: start on rise, stop on fall, clear run enable.
// - Toggle mode: active edges start, stop, restart; enable kept.
// - Under pin control run enable only arms; first edge starts.
// - Under CPU control count follows run enable, pin ignored.
// - CPU run enable starts at once; mode select needs pin control.
// - After switch to pin stop, next rise stops the counter.
// - Writing clear zeroes the count only; bit reads as zero.
// - Every reset stops the counter and clears the count.
// - Count is read only: low, middle, high digit nibbles.
// - Count spans 000 to 999 in BCD.
// - Seconds flag sets at 999, clears on control b read.
// - Changing edge select may itself start or stop the counter.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "stopwatch_params.svh"

module millisecond_bcd_stopwatch #(
    parameter int DEB_SAMPLES = 2
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [2:0] ADDR,
    input wire stopwatch_pkg::nibble_t WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output stopwatch_pkg::nibble_t RDATA,
    input wire logic TRIGGER_PIN,
    input wire logic FAST_TAP_TICK,
    input wire logic SLOW_TAP_TICK,
    input wire logic MS_TICK,
    output logic STOPWATCH_IRQ
);
    import stopwatch_pkg::*;

    // ********************************************************
    // Declarations
    // ********************************************************
    logic wr_a;
    logic wr_b;
    logic rd_b;
    logic counter_clear;
    logic run_enable_ff;
    logic pin_ctrl_ff;
    logic meas_ff;
    logic deb_sel_ff;
    logic edge_sel_ff;
    logic irq_period_ff;
    logic seconds_flag_ff;
    logic pin_meta_ff;
    logic pin_sync_ff;
    logic deb_level;
    logic deb_tick;
    logic internal_trigger;
    logic trig_prev_ff;
    logic trig_rise;
    logic trig_fall;
    run_state_t state_ff;
    run_state_t nxt_state;
    logic hw_stop;
    logic counting;
    logic advance;
    logic reach_top;
    logic [11:0] count;
    logic tenth_carry;
    logic wrap;

    // ********************************************************
    // Register port decode
    // ********************************************************

    // Address compare for the two writable and the flag register
    assign wr_a = WR_STB && (ADDR == `SW_IDX_CTRL_A);
    assign wr_b = WR_STB && (ADDR == `SW_IDX_CTRL_B);
    assign rd_b = RD_STB && (ADDR == `SW_IDX_CTRL_B);

    // Clear is a write side effect only, never stored
    assign counter_clear = wr_a && WDATA[`SW_A_CLR];

    // ********************************************************
    // Control register a
    // ********************************************************

    // Mode bits; reset leaves CPU control and start-stop mode
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pin_ctrl_ff <= `SW_RST_BIT;
            meas_ff <= `SW_RST_BIT;
        end else if (wr_a) begin
            pin_ctrl_ff <= WDATA[`SW_A_PIN];
            meas_ff <= WDATA[`SW_A_MEAS];
        end
    end

    // Run enable: a software write wins over the hardware
    // clear at a pulse end, so a fresh arm is never lost
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            run_enable_ff <= `SW_RST_BIT;
        end else if (wr_a) begin
            run_enable_ff <= WDATA[`SW_A_RUN];
        end else if (hw_stop) begin
            run_enable_ff <= 1'b0;
        end
    end

    // ********************************************************
    // Control register b
    // ********************************************************

    // Debounce tap, trigger edge and interrupt period
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            deb_sel_ff <= `SW_RST_BIT;
            edge_sel_ff <= `SW_RST_BIT;
            irq_period_ff <= `SW_RST_BIT;
        end else if (wr_b) begin
            deb_sel_ff <= WDATA[`SW_B_DEB];
            edge_sel_ff <= WDATA[`SW_B_EDGE];
            irq_period_ff <= WDATA[`SW_B_IRQP];
        end
    end

    // Seconds flag: reaching 999 beats the read clear
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            seconds_flag_ff <= `SW_RST_BIT;
        end else if (reach_top) begin
            seconds_flag_ff <= 1'b1;
        end else if (rd_b) begin
            seconds_flag_ff <= 1'b0;
        end
    end

    // ********************************************************
    // Trigger path
    // ********************************************************

    // Two flops before the pin reaches any logic; reset to the
    // pulled-up idle level to match the debouncer
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pin_meta_ff <= 1'b1;
            pin_sync_ff <= 1'b1;
        end else begin
            pin_meta_ff <= TRIGGER_PIN;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Select 0 takes the fast tap; the slow tap saves power
    // at the cost of millisecond resolution on the edges
    assign deb_tick = deb_sel_ff ? SLOW_TAP_TICK : FAST_TAP_TICK;

    trigger_debounce #(
        .SAMPLES(DEB_SAMPLES)
    ) u_debounce (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .pin_level(pin_sync_ff),
        .tap_tick(deb_tick),
        .stable(deb_level)
    );

    // Polarity uses only this counter's own select, so a
    // change of the select alone can make an edge
    assign internal_trigger = edge_sel_ff ? deb_level : ~deb_level;

    // Edge detect on the internal trigger
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            trig_prev_ff <= `SW_RST_BIT;
        end else begin
            trig_prev_ff <= internal_trigger;
        end
    end

    assign trig_rise = internal_trigger & ~trig_prev_ff;
    assign trig_fall = ~internal_trigger & trig_prev_ff;

    // ********************************************************
    // Run state machine
    // ********************************************************

    // Edges are only looked at in the pin states, so under
    // CPU control neither edge nor mode select has effect
    always_comb begin
        nxt_state = state_ff;
        hw_stop = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (run_enable_ff && !pin_ctrl_ff) begin
                    nxt_state = ST_RUN_CPU;
                end else if (run_enable_ff) begin
                    nxt_state = ST_ARMED;
                end
            end
            ST_RUN_CPU: begin
                if (!run_enable_ff) begin
                    nxt_state = ST_IDLE;
                end else if (pin_ctrl_ff) begin
                    nxt_state = ST_WAIT_STOP;
                end
            end
            ST_ARMED: begin
                if (!run_enable_ff) begin
                    nxt_state = ST_IDLE;
                end else if (!pin_ctrl_ff) begin
                    nxt_state = ST_RUN_CPU;
                end else if (trig_rise) begin
                    nxt_state = ST_RUN_PIN;
                end
            end
            ST_RUN_PIN: begin
                if (!run_enable_ff) begin
                    nxt_state = ST_IDLE;
                end else if (!pin_ctrl_ff) begin
                    nxt_state = ST_RUN_CPU;
                end else if (meas_ff && trig_fall) begin
                    nxt_state = ST_IDLE;
                    hw_stop = 1'b1;
                end else if (!meas_ff && trig_rise) begin
                    nxt_state = ST_ARMED;
                end
            end
            ST_WAIT_STOP: begin
                if (!run_enable_ff) begin
                    nxt_state = ST_IDLE;
                end else if (!pin_ctrl_ff) begin
                    nxt_state = ST_RUN_CPU;
                end else if (trig_rise && meas_ff) begin
                    nxt_state = ST_IDLE;
                    hw_stop = 1'b1;
                end else if (trig_rise) begin
                    nxt_state = ST_ARMED;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign counting = (state_ff == ST_RUN_CPU) ||
        (state_ff == ST_RUN_PIN) || (state_ff == ST_WAIT_STOP);

    // ********************************************************
    // BCD count
    // ********************************************************

    // One step per prescaler millisecond tick while running
    assign advance = MS_TICK && counting;
    assign reach_top = advance && !counter_clear &&
        (count == `SW_COUNT_PRE_TOP);

    bcd_count #(
        .DIGITS(3)
    ) u_count (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .clear(counter_clear),
        .advance(advance),
        .count(count),
        .tenth_carry(tenth_carry),
        .wrap(wrap)
    );

    // Interrupt request pulse for the interrupt controller
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            STOPWATCH_IRQ <= `SW_RST_BIT;
        end else begin
            STOPWATCH_IRQ <= irq_period_ff ? wrap : tenth_carry;
        end
    end

    // ********************************************************
    // Read data, valid only in the cycle after the strobe
    // ********************************************************

    // Digits are read only: writes to them are dropped
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST || !RD_STB) begin
            RDATA <= `SW_RST_NIBBLE;
        end else begin
            case (ADDR)
                `SW_IDX_CTRL_A: begin
                    RDATA <= {run_enable_ff, pin_ctrl_ff, meas_ff,
                        1'b0};
                end
                `SW_IDX_CTRL_B: begin
                    RDATA <= {deb_sel_ff, edge_sel_ff, irq_period_ff,
                        seconds_flag_ff};
                end
                `SW_IDX_DIG_L: begin
                    RDATA <= count[3:0];
                end
                `SW_IDX_DIG_M: begin
                    RDATA <= count[7:4];
                end
                `SW_IDX_DIG_H: begin
                    RDATA <= count[11:8];
                end
                default: begin
                    RDATA <= `SW_RST_NIBBLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************

    default clocking cb @(posedge SYS_CLK);
    endclocking

    default disable iff (SYS_RST);

    sequence s_sw_clear;
        wr_a && WDATA[`SW_A_CLR];
    endsequence

    sequence s_pulse_end;
        state_ff == ST_RUN_PIN && run_enable_ff && pin_ctrl_ff &&
            meas_ff && trig_fall && !wr_a;
    endsequence

    sequence s_toggle_edge;
        (state_ff == ST_RUN_PIN || state_ff == ST_WAIT_STOP) &&
            run_enable_ff && pin_ctrl_ff && !meas_ff && trig_rise &&
            !wr_a;
    endsequence

    sequence s_tenth_step;
        advance && !counter_clear && !irq_period_ff &&
            count[7:0] == `SW_LOW_TOP;
    endsequence

    a_clear_zero_count:
    assert property (s_sw_clear |=> count == `SW_COUNT_ZERO)
        else $error("clear write left a nonzero count");

    a_clear_bit_reads:
    assert property ((RD_STB && ADDR == `SW_IDX_CTRL_A)
        |=> !RDATA[`SW_A_CLR])
        else $error("clear bit read back as one");

    a_cpu_run_counts:
    assert property ((run_enable_ff && !pin_ctrl_ff)
        |=> counting)
        else $error("CPU controlled run did not count");

    a_disabled_stops:
    assert property (!run_enable_ff |=> !counting)
        else $error("counter ran without run enable");

    a_pin_arm_only:
    assert property ((state_ff == ST_IDLE && run_enable_ff &&
        pin_ctrl_ff) |=> !counting)
        else $error("pin controlled arm started the count");

    a_pulse_stop_clr:
    assert property (s_pulse_end |=> !counting && !run_enable_ff)
        else $error("pulse end did not stop and clear enable");

    a_toggle_keeps_en:
    assert property (s_toggle_edge
        |=> state_ff == ST_ARMED && run_enable_ff)
        else $error("toggle stop lost run enable");

    a_irq_tenth_pulse:
    assert property (s_tenth_step |=> STOPWATCH_IRQ ##1 !STOPWATCH_IRQ)
        else $error("tenth second request missing");

    a_irq_no_step:
    assert property (!advance |=> !STOPWATCH_IRQ)
        else $error("request raised without a count step");

    a_seconds_set:
    assert property (reach_top
        |=> seconds_flag_ff && count == `SW_COUNT_TOP)
        else $error("seconds flag not set at 999");

    a_reset_stops:
    assert property (@(posedge SYS_CLK) disable iff (1'b0)
        SYS_RST |=> !counting && !run_enable_ff &&
        count == `SW_COUNT_ZERO)
        else $error("reset left the counter running");

endmodule
`default_nettype wire

// *** pin_source.sv ***
// Far-side model: prescaler taps and the latched trigger pin
`timescale 1ns/10ps
`default_nettype none

module pin_source #(
    parameter int FAST_DIV = 4,
    parameter int SLOW_DIV = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic level_req,
    output logic pin,
    output logic fast_tick,
    output logic slow_tick
);
    logic [7:0] div_ff;

    // Free running prescaler; both taps are one-cycle pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Taps stay quiet in reset so no stale sample reaches the filter
    assign fast_tick = !rst && ((int'(div_ff) % FAST_DIV) == 0);
    assign slow_tick = !rst && ((int'(div_ff) % SLOW_DIV) == 0);

    // Port latch; pull-up keeps the pin high until told otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            pin <= 1'b1;
        end else begin
            pin <= level_req;
        end
    end
endmodule

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the millisecond BCD stopwatch
`timescale 1ns/10ps
`default_nettype none
`include "stopwatch_params.svh"

module testbench import stopwatch_pkg::*;;
    typedef struct {int n; logic per; logic [11:0] cnt; int irq; logic secf;} row_t;
    logic SYS_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [2:0] ADDR = 3'h0;
    nibble_t WDATA = 4'h0;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic MS_TICK = 1'b0;
    logic pin_req = 1'b1;
    nibble_t RDATA;
    logic STOPWATCH_IRQ, TRIGGER_PIN, fast_tick, slow_tick;
    int err_total = 0;
    int tests_run = 0;
    int irq_seen = 0;
    int irq0;
    row_t rows [5] = '{'{5, 1'b0, 12'h005, 0, 1'b0},
        '{100, 1'b0, 12'h100, 1, 1'b0}, '{999, 1'b0, 12'h999, 9, 1'b1},
        '{1000, 1'b1, 12'h000, 1, 1'b1}, '{999, 1'b1, 12'h999, 0, 1'b1}};

    millisecond_bcd_stopwatch #(.DEB_SAMPLES(2)) dut (.SYS_CLK(SYS_CLK),
        .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
        .RD_STB(RD_STB), .RDATA(RDATA), .TRIGGER_PIN(TRIGGER_PIN),
        .FAST_TAP_TICK(fast_tick), .SLOW_TAP_TICK(slow_tick),
        .MS_TICK(MS_TICK), .STOPWATCH_IRQ(STOPWATCH_IRQ));

    pin_source far (.clk(SYS_CLK), .rst(SYS_RST), .level_req(pin_req),
        .pin(TRIGGER_PIN), .fast_tick(fast_tick), .slow_tick(slow_tick));

    // Clock of 100 ns period
    always #50 SYS_CLK = ~SYS_CLK;

    // Interrupt pulses are counted as they stand, one cycle each
    always @(posedge SYS_CLK) begin
        if (STOPWATCH_IRQ === 1'b1) begin
            irq_seen++;
        end
    end

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                       input string msg);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg,
                     seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input nibble_t d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge SYS_CLK);
        WR_STB <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output nibble_t d);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge SYS_CLK);
        RD_STB <= 1'b0;
        #1 d = RDATA;
    endtask

    task automatic chkr(input logic [2:0] a, input nibble_t e, input string m);
        nibble_t d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, e}, m);
    endtask

    // Digits are read one by one, so only while the count holds still
    task automatic chkc(input logic [11:0] e, input string m);
        nibble_t h, md, l;
        rd(`SW_IDX_DIG_H, h);
        rd(`SW_IDX_DIG_M, md);
        rd(`SW_IDX_DIG_L, l);
        chk({h, md, l}, e, m);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge SYS_CLK);
            MS_TICK <= 1'b1;
            @(posedge SYS_CLK);
            MS_TICK <= 1'b0;
        end
    endtask

    // Settle time covers the two sync flops and the debounce samples
    task automatic pin_to(input logic v, input int settle);
        @(posedge SYS_CLK);
        pin_req <= v;
        repeat (settle) @(posedge SYS_CLK);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 7300 cycles of the tests
    initial begin
        repeat (30000) @(posedge SYS_CLK);
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        repeat (5) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        // Every register starts at zero; data digits ignore writes
        for (int a = 0; a < 5; a++) begin
            chkr(a[2:0], 4'h0, "reset value");
        end
        wr(`SW_IDX_DIG_L, 4'hF);
        wr(3'h5, 4'hF);
        chkr(`SW_IDX_DIG_L, 4'h0, "digit written");
        chkr(3'h5, 4'h0, "unmapped read");
        // Reset in mid-run stops the counter and clears the count
        wr(`SW_IDX_CTRL_A, 4'h8);
        ticks(3);
        chkc(12'h003, "before reset");
        SYS_RST <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        chkc(12'h000, "count after reset");
        chkr(`SW_IDX_CTRL_A, 4'h0, "ctrl after reset");
        ticks(2);
        chkc(12'h000, "stopped after reset");
        $display("test reset finished");

        // Ordinary CPU-run cases: clear, configure, run, stop, read
        foreach (rows[i]) begin
            irq0 = irq_seen;
            wr(`SW_IDX_CTRL_A, 4'h1);
            chkr(`SW_IDX_CTRL_A, 4'h0, "clear bit");
            wr(`SW_IDX_CTRL_B, {2'b00, rows[i].per, 1'b0});
            wr(`SW_IDX_CTRL_A, 4'h8);
            ticks(rows[i].n);
            wr(`SW_IDX_CTRL_A, 4'h0);
            chkc(rows[i].cnt, "count");
            chk(12'(irq_seen - irq0), 12'(rows[i].irq), "irq pulses");
            chkr(`SW_IDX_CTRL_B, {2'b00, rows[i].per, rows[i].secf},
                 "seconds flag");
            chkr(`SW_IDX_CTRL_B, {2'b00, rows[i].per, 1'b0}, "flag read");
        end
        $display("test rows finished");

        // Pin activity must not disturb a CPU run
        wr(`SW_IDX_CTRL_A, 4'h1);
        wr(`SW_IDX_CTRL_A, 4'h8);
        pin_to(1'b0, 30);
        pin_to(1'b1, 30);
        ticks(3);
        chkc(12'h003, "cpu run with pin");
        wr(`SW_IDX_CTRL_A, 4'h0);
        $display("test cpu_pin finished");

        // Pulse width: armed, start on rise, stop on fall
        pin_to(1'b0, 30);
        wr(`SW_IDX_CTRL_B, 4'h4);
        wr(`SW_IDX_CTRL_A, 4'h1);
        wr(`SW_IDX_CTRL_A, 4'hE);
        ticks(2);
        chkc(12'h000, "armed only");
        pin_to(1'b1, 30);
        ticks(4);
        chkc(12'h004, "pulse start");
        pin_to(1'b0, 30);
        ticks(3);
        chkc(12'h004, "pulse stop");
        chkr(`SW_IDX_CTRL_A, 4'h6, "run cleared");
        $display("test pulse finished");

        // Toggle on falling pin edges with the slow debounce tap
        pin_to(1'b1, 30);
        wr(`SW_IDX_CTRL_B, 4'h8);
        wr(`SW_IDX_CTRL_A, 4'h1);
        wr(`SW_IDX_CTRL_A, 4'hC);
        pin_to(1'b0, 3);
        pin_to(1'b1, 80);
        ticks(1);
        chkc(12'h000, "glitch filtered");
        pin_to(1'b0, 80);
        ticks(2);
        chkc(12'h002, "toggle start");
        pin_to(1'b1, 80);
        pin_to(1'b0, 80);
        ticks(2);
        chkc(12'h002, "toggle stop");
        chkr(`SW_IDX_CTRL_A, 4'hC, "run kept");
        pin_to(1'b1, 80);
        pin_to(1'b0, 80);
        ticks(1);
        chkc(12'h003, "toggle restart");
        wr(`SW_IDX_CTRL_A, 4'h0);
        $display("test toggle finished");

        // CPU start, start condition made by the edge select, pin stop
        wr(`SW_IDX_CTRL_B, 4'h4);
        wr(`SW_IDX_CTRL_A, 4'h1);
        wr(`SW_IDX_CTRL_A, 4'hA);
        ticks(3);
        wr(`SW_IDX_CTRL_B, 4'h0);
        pin_to(1'b0, 30);
        wr(`SW_IDX_CTRL_A, 4'hE);
        ticks(2);
        chkc(12'h005, "cpu start");
        pin_to(1'b1, 30);
        ticks(1);
        chkc(12'h006, "fall ignored");
        pin_to(1'b0, 30);
        ticks(2);
        chkc(12'h006, "pin stop");
        chkr(`SW_IDX_CTRL_A, 4'h6, "run cleared");
        $display("test cpu_start_pin_stop finished");
        stop_test();
    end
endmodule

`default_nettype wire
